// *** hdl/gcs_bank.sv ***
// gcs_bank.sv: register bank for eight channel pins and the input sequencer,
// reached over classic wishbone with 32-bit data.
// assumes: a single wishbone master; pads synchronous to mclk; a conversion
// engine outside reads the selected channel.
`timescale 1ns/1ps
`include "gcs_params.svh"
module gcs_bank
    import gcs_pkg::*;
#(
    parameter int NCH = 8,
    parameter int STEP_CYC = `GCS_STEP_CYC
) (
    input wire logic mclk, // system clock, 50 MHz
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic wb_err_o, // unmapped address answer
    input wire logic [NCH-1:0] pad_in, // pad levels
    output logic [NCH-1:0] pad_out, // pad output value
    output logic [NCH-1:0] pad_oe_n, // pad drive enable, low drives
    output logic [2:0] conv_channel, // channel for next conversion
    output logic conv_valid // conv_channel is meaningful
);

    // refuse channel counts and dwell lengths the logic cannot serve
    if (NCH != 8) begin : g_bad_nch
        $error("gcs_bank serves eight channels only");
    end
    if (STEP_CYC < 1 || STEP_CYC > 65536) begin : g_bad_step
        $error("gcs_bank step count must lie in 1 to 65536");
    end

    // ======================================================================
    // state
    logic [7:0] func_r, func_nxt;
    logic [7:0] dir_r, dir_nxt;
    logic [7:0] drive_r, drive_nxt;
    logic [7:0] out_r, out_nxt;
    logic [7:0] seq_r, seq_nxt;
    logic [7:0] man_r, man_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic ack_r, ack_nxt;
    logic err_r, err_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [2:0] chan_r, chan_nxt;
    logic valid_r, valid_nxt;
    logic [15:0] dwell_r, dwell_nxt;

    // links to the pin stage
    logic [7:0] in_level;
    gcs_pindrv_t drv;
    gcs_pincfg_t cfg;

    // ======================================================================
    // sequencer state and dwell reload
    typedef enum logic [1:0] {GCS_SQ_IDLE, GCS_SQ_DWELL} gcs_sq_t;
    gcs_sq_t sq_r, sq_nxt;
    localparam logic [15:0] DWELL_LOAD = 16'(STEP_CYC - 1);

    // ======================================================================
    // decoded controls
    gcs_mode_t mode;
    logic run;
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic hit;
    logic [31:0] stat_word;

    // field views of the control registers and the bus request
    assign mode = gcs_mode_t'(seq_r[`GCS_SCAN_MODE_SELECT_LO +: 2]);
    assign run = seq_r[`GCS_SEQ_RUN_BIT];
    assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign idx = {2'h0, wb_adr_i[7:2]};
    assign wbyte = wb_dat_i[7:0];

    // status word: valid flag in bit 11, channel in bits 2:0
    assign stat_word = {20'h0, valid_r, 8'h0, chan_r};

    // ======================================================================
    // next ascending enabled channel after chan_r, wrapping
    function automatic logic [3:0] next_chan(input logic [7:0] m,
                                            input logic [2:0] c);
        logic [3:0] r;
        logic [2:0] k;
        r = 4'h8;
        for (int j = 7; j >= 1; j--) begin
            k = c + 3'(j);
            if (m[k]) begin
                r = {1'b0, k};
            end
        end
        if (r[3] && m[c]) begin
            r = {1'b0, c};
        end
        return r;
    endfunction

    // first enabled channel from zero upward
    function automatic logic [3:0] first_chan(input logic [7:0] m);
        logic [3:0] r;
        r = 4'h8;
        for (int j = 7; j >= 0; j--) begin
            if (m[j]) begin
                r = 4'(j);
            end
        end
        return r;
    endfunction

    // ======================================================================
    // bus answer: decode and read mux; answer one cycle after request
    always_comb begin
        ack_nxt = 1'b0;
        err_nxt = 1'b0;
        dat_nxt = dat_r;
        hit = 1'b1;
        case (idx)
            `GCS_IDX_FUNC: dat_nxt = {24'h0, func_r};
            `GCS_IDX_DIR: dat_nxt = {24'h0, dir_r};
            `GCS_IDX_DRIVE: dat_nxt = {24'h0, drive_r};
            `GCS_IDX_OUT: dat_nxt = {24'h0, out_r};
            `GCS_IDX_IN: dat_nxt = {24'h0, in_level}; // R3
            `GCS_IDX_SEQ: dat_nxt = {24'h0, seq_r}; // R10
            `GCS_IDX_MAN: dat_nxt = {24'h0, man_r}; // R10
            `GCS_IDX_MASK: dat_nxt = {24'h0, mask_r};
            `GCS_IDX_STAT: dat_nxt = stat_word;
            default: hit = 1'b0;
        endcase
        if (req) begin
            ack_nxt = hit;
            err_nxt = ~hit;
            if (!hit || wb_we_i) begin
                dat_nxt = 32'h0;
            end
        end
    end

    // ======================================================================
    // register writes; reserved bits are dropped on the way in
    always_comb begin
        func_nxt = func_r;
        dir_nxt = dir_r;
        drive_nxt = drive_r;
        out_nxt = out_r;
        seq_nxt = seq_r;
        man_nxt = man_r;
        mask_nxt = mask_r;
        if (wr && hit) begin
            case (idx)
                `GCS_IDX_FUNC: func_nxt = wbyte; // R12
                `GCS_IDX_DIR: dir_nxt = wbyte; // R13
                `GCS_IDX_DRIVE: drive_nxt = wbyte; // R1
                `GCS_IDX_OUT: out_nxt = wbyte; // R2
                `GCS_IDX_SEQ: seq_nxt = wbyte & `GCS_SEQ_WMASK; // R10 R5
                `GCS_IDX_MAN: man_nxt = wbyte & `GCS_MAN_WMASK; // R10
                `GCS_IDX_MASK: mask_nxt = wbyte; // R9
                default: ;
            endcase
        end
    end

    // ======================================================================
    // sequencer: picks the channel handed to the conversion engine
    always_comb begin
        logic [3:0] pick;
        pick = 4'h8;
        sq_nxt = sq_r;
        chan_nxt = chan_r;
        valid_nxt = 1'b0;
        dwell_nxt = dwell_r;
        case (mode)
            GCS_MODE_MANUAL: begin
                sq_nxt = GCS_SQ_IDLE;
                chan_nxt = man_r[2:0]; // R6
                valid_nxt = ~man_r[3]; // R7
            end
            GCS_MODE_AUTO: begin
                case (sq_r)
                    GCS_SQ_IDLE: begin
                        pick = first_chan(mask_r);
                        if (run && !pick[3]) begin // R4
                            sq_nxt = GCS_SQ_DWELL;
                            chan_nxt = pick[2:0];
                            valid_nxt = 1'b1;
                            dwell_nxt = DWELL_LOAD;
                        end
                    end
                    GCS_SQ_DWELL: begin
                        valid_nxt = 1'b1;
                        if (!run) begin // R4
                            sq_nxt = GCS_SQ_IDLE;
                            valid_nxt = 1'b0;
                        end else if (dwell_r != 16'h0) begin
                            dwell_nxt = dwell_r - 16'h1;
                        end else begin
                            pick = next_chan(mask_r, chan_r); // R9
                            if (pick[3]) begin
                                sq_nxt = GCS_SQ_IDLE;
                                valid_nxt = 1'b0;
                            end else begin
                                chan_nxt = pick[2:0];
                                dwell_nxt = DWELL_LOAD;
                            end
                        end
                    end
                    default: sq_nxt = GCS_SQ_IDLE;
                endcase
            end
            default: begin
                // on-the-fly selection is made by the serial frame itself
                sq_nxt = GCS_SQ_IDLE;
            end
        endcase
    end

    // ======================================================================
    // configuration registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            func_r <= `GCS_RST_BYTE;
            dir_r <= `GCS_RST_BYTE;
            drive_r <= `GCS_RST_BYTE;
            out_r <= `GCS_RST_BYTE; // R11
            seq_r <= `GCS_RST_BYTE; // R11
            man_r <= `GCS_RST_BYTE; // R11
            mask_r <= `GCS_RST_BYTE; // R11
        end else begin
            func_r <= func_nxt;
            dir_r <= dir_nxt;
            drive_r <= drive_nxt;
            out_r <= out_nxt;
            seq_r <= seq_nxt;
            man_r <= man_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ======================================================================
    // bus answer registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ======================================================================
    // sequencer registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chan_r <= `GCS_RST_CHAN;
            valid_r <= 1'b0;
            dwell_r <= 16'h0;
            sq_r <= GCS_SQ_IDLE;
        end else begin
            chan_r <= chan_nxt;
            valid_r <= valid_nxt;
            dwell_r <= dwell_nxt;
            sq_r <= sq_nxt;
        end
    end

    // ======================================================================
    // pad stage
    assign cfg = '{func: func_r, dir: dir_r, drive: drive_r, level: out_r};

    // pin stage registers the pad drive and the input readback
    gcs_pin_stage #(
        .NCH(NCH)
    ) u_pins (
        .mclk(mclk),
        .arst_n(arst_n),
        .cfg(cfg),
        .pad_in(pad_in),
        .drv(drv),
        .in_level(in_level)
    );

    // pad outputs come from the pin stage flops
    assign pad_out = drv.value; // flop in pin stage
    assign pad_oe_n = drv.oe_n; // flop in pin stage

    // bus outputs straight from their flops
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;

    // channel handed to the conversion engine
    assign conv_channel = chan_r;
    assign conv_valid = valid_r;

endmodule

// *** hdl/gcs_params.svh ***
// gcs_params.svh: register offsets, field positions, reset values for the
// channel pin and sequencer register bank.
// assumes: included by the bank package users; definitions only.
// Operation
// [R1] drive bit: 0 open-drain, 1 push-pull
// [R2] output level bit sets pin logic level
// [R3] input level register reads digital input pins
// [R4] run bit in auto mode scans enabled channels
// [R5] mode: 00 manual, 01 auto, 10 fly
// [R6] manual mode converts the manual channel id
// [R7] ids 0-7 valid; top bit set reserved
// [R8] host picks manual channel set analog
// [R9] scan mask bit includes channel in scan
// [R10] reserved bits read back as zero
// [R11] listed registers reset to zero
// [R12] function bit: 0 analog, 1 general pin
// [R13] direction bit: 0 input, 1 output
// [R14] output bits act only on general outputs
`ifndef GCS_PARAMS_SVH
`define GCS_PARAMS_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define GCS_IDX_FUNC 8'h05
`define GCS_IDX_DIR 8'h07
`define GCS_IDX_DRIVE 8'h09
`define GCS_IDX_OUT 8'h0b
`define GCS_IDX_IN 8'h0d
`define GCS_IDX_SEQ 8'h10
`define GCS_IDX_MAN 8'h11
`define GCS_IDX_MASK 8'h12
`define GCS_IDX_STAT 8'h13

// ==========================================================================
// field positions
`define GCS_SEQ_RUN_BIT 4
`define GCS_SCAN_MODE_SELECT_LO 0
`define GCS_SEQ_WMASK 8'h13
`define GCS_MAN_WMASK 8'h0f

// ==========================================================================
// reset values
`define GCS_RST_BYTE 8'h00
`define GCS_RST_CHAN 3'h0

// ==========================================================================
// timing: dwell of each auto-scan step
`define GCS_STEP_NS 1000
`define GCS_CLK_NS 20
`define GCS_STEP_CYC ((`GCS_STEP_NS + `GCS_CLK_NS - 1) / `GCS_CLK_NS)

`endif

// *** hdl/gcs_pkg.sv ***
// gcs_pkg.sv: types shared by the channel pin and sequencer register bank.
// assumes: nothing beyond a SystemVerilog compiler.
package gcs_pkg;

    // ======================================================================
    // scan modes
    typedef enum logic [1:0] {
        GCS_MODE_MANUAL = 2'h0,
        GCS_MODE_AUTO = 2'h1,
        GCS_MODE_FLY = 2'h2,
        GCS_MODE_RSVD = 2'h3
    } gcs_mode_t;

    // ======================================================================
    // pin configuration carried to the pin stage
    typedef struct packed {
        logic [7:0] func;
        logic [7:0] dir;
        logic [7:0] drive;
        logic [7:0] level;
    } gcs_pincfg_t;

    // drive of the pins: output value and active-low enable
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] oe_n;
    } gcs_pindrv_t;

endpackage

// *** hdl/gcs_pin_stage.sv ***
// gcs_pin_stage.sv: per-channel pad control from the pin configuration.
// assumes: pad inputs synchronous to mclk; oe_n low means the pad is driven.
`timescale 1ns/1ps
`include "gcs_params.svh"
module gcs_pin_stage
    import gcs_pkg::*;
#(
    parameter int NCH = 8
) (
    input wire logic mclk, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire gcs_pincfg_t cfg, // pin configuration
    input wire logic [NCH-1:0] pad_in, // pad levels
    output gcs_pindrv_t drv, // registered pad drive
    output logic [NCH-1:0] in_level // registered input readback
);

    // only eight pad lanes exist in the drive and readback words
    if (NCH != 8) begin : g_bad_nch
        $error("gcs_pin_stage serves eight channels only");
    end

    gcs_pindrv_t drv_nxt;
    logic [NCH-1:0] in_nxt;

    // per channel: decide drive and capture input
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic is_out;
        assign is_out = cfg.func[i] & cfg.dir[i]; // R12 R13 R14
        always_comb begin
            // push-pull drives both levels, open-drain only pulls low
            drv_nxt.value[i] = cfg.level[i]; // R2
            drv_nxt.oe_n[i] = ~(is_out & (cfg.drive[i] | ~cfg.level[i])); // R1
            in_nxt[i] = (cfg.func[i] & ~cfg.dir[i]) ? pad_in[i] : 1'b0; // R3
        end
    end

    // register the pad controls and readback
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            drv.value <= `GCS_RST_BYTE;
            drv.oe_n <= 8'hff;
            in_level <= `GCS_RST_BYTE; // R11
        end else begin
            drv <= drv_nxt;
            in_level <= in_nxt;
        end
    end

endmodule

// *** test/gcs_pad_model.sv ***
// gcs_pad_model.sv: the board around the eight channel pins.
// assumes: pullup on every pin; an outside source may drive input pins.
`timescale 1ns/1ps
module gcs_pad_model (
    input wire logic [7:0] pad_out, // design output value
    input wire logic [7:0] pad_oe_n, // design enable, low drives
    input wire logic [7:0] ext_en, // outside source drives the pin
    input wire logic [7:0] ext_lv, // level of the outside source
    output logic [7:0] pad_in // resolved pin level
);
    // a released pin follows the outside source, else the pullup
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_lv[i];
            else pad_in[i] = 1'b1;
        end
    end
endmodule

// *** test/gcs_bank_properties.sv ***
// gcs_bank_properties.sv: port assertions for the register bank.
// assumes: bound into gcs_bank; shadows registers from acked writes.
`timescale 1ns/1ps
module gcs_bank_properties #(
    parameter int NCH = 8,
    parameter int STEP_CYC = 50
) (
    input wire logic mclk, // system clock
    input wire logic arst_n, // reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic wb_err_o, // error answer
    input wire logic [NCH-1:0] pad_out, // pad value
    input wire logic [NCH-1:0] pad_oe_n, // pad enable, low drives
    input wire logic [2:0] conv_channel, // selected channel
    input wire logic conv_valid // selection valid
);
    logic [7:0] fn_r, dr_r, dv_r, ol_r, sq_r, mc_r, mk_r;
    logic ok_r;
    wire wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    // ==================================================================
    // shadow registers, updated at the edge that sees the write acked
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {fn_r, dr_r, dv_r, ol_r, sq_r, mc_r, mk_r} <= '0;
            ok_r <= 1'b0;
        end else begin
            ok_r <= 1'b1;
            if (wr_ok) begin
                case (wb_adr_i[7:2])
                    6'h05: fn_r <= wb_dat_i[7:0];
                    6'h07: dr_r <= wb_dat_i[7:0];
                    6'h09: dv_r <= wb_dat_i[7:0];
                    6'h0b: ol_r <= wb_dat_i[7:0];
                    6'h10: sq_r <= wb_dat_i[7:0] & 8'h13;
                    6'h11: mc_r <= wb_dat_i[7:0] & 8'h0f;
                    6'h12: mk_r <= wb_dat_i[7:0];
                    default: ;
                endcase
            end
        end
    end
    // ==================================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        && !wb_err_o |=> wb_ack_o || wb_err_o) else $error("no bus answer");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_pad_level: assert property (ok_r |-> pad_out == ol_r)
        else $error("pad value differs from output level");
    a_pad_enable: assert property (ok_r |->
        pad_oe_n == ~(fn_r & dr_r & (dv_r | ~ol_r)))
        else $error("pad enable wrong");
    a_rsvd_zero: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i[7:3] == 5'h08 |-> ((wb_dat_o &
        ~((wb_adr_i[7:2] == 6'h10) ? 32'h13 : 32'h0f)) == 32'h0))
        else $error("reserved bits read nonzero");
    a_manual_pick: assert property (ok_r && sq_r[1:0] == 2'h0 |->
        conv_valid == !mc_r[3] && (mc_r[3] || conv_channel == mc_r[2:0]))
        else $error("manual channel wrong");
    a_fly_idle: assert property (ok_r && sq_r[1] |-> !conv_valid)
        else $error("channel valid outside manual and auto");
    a_auto_stop: assert property (ok_r && sq_r[1:0] == 2'h1 && !sq_r[4]
        |-> !conv_valid) else $error("scan runs while stopped");
    a_scan_mask: assert property (conv_valid && sq_r[1:0] == 2'h1
        |-> mk_r[conv_channel]) else $error("scan left the mask");
    c_err: cover property (wb_err_o);
    c_scan: cover property (conv_valid && sq_r[1:0] == 2'h1);
    c_drive: cover property (pad_oe_n != 8'hff);
endmodule
bind gcs_bank gcs_bank_properties #(.NCH(NCH), .STEP_CYC(STEP_CYC))
    gcs_bank_properties_i (.mclk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .pad_out, .pad_oe_n, .conv_channel, .conv_valid);

// *** test/gcs_bank_tb_top.sv ***
// gcs_bank_tb_top.sv: register, pin and scan tests of the register bank.
// assumes: the pad model stands on the pins; short scan dwell of 2.
`timescale 1ns/1ps
module gcs_bank_tb_top;
    logic mclk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h0, ext_en = 8'h0, ext_lv = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, q, dat_o;
    logic e, ack, err, cv;
    logic [7:0] pad_in, pad_out, oe_n;
    logic [2:0] ch;
    logic [2:0] seen [$];
    logic [2:0] nx [8] = '{3'h0, 3'h0, 3'h5, 3'h0, 3'h0, 3'h7, 3'h0, 3'h2};
    logic [5:0] ri [6] = '{6'h0b, 6'h0d, 6'h10, 6'h11, 6'h12, 6'h09};
    int mismatches = 0, cmp_count = 0, cycles = 0;
    gcs_bank #(.STEP_CYC(2)) gcs_bank_i (.mclk(mclk), .arst_n(arst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(err), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(oe_n), .conv_channel(ch), .conv_valid(cv));
    gcs_pad_model gcs_pad_model_i (.pad_out(pad_out), .pad_oe_n(oe_n),
        .ext_en(ext_en), .ext_lv(ext_lv), .pad_in(pad_in));
    // ==================================================================
    // clock and hang guard
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // ==================================================================
    // closing report
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // one classic cycle, entered just after a rising edge
    task automatic bus(input logic w, input logic [5:0] idx, logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        dat <= {24'h0, d};
        sel <= 4'h1;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = dat_o;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [5:0] idx, logic [7:0] x, string name);
        bus(1'b0, idx, 8'h0);
        check(name, {24'h0, x}, q);
    endtask
    // ==================================================================
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        foreach (ri[i]) rd(ri[i], 8'h00, "reset value");
        check("conv select", 32'h8, {28'h0, cv, ch});
        bus(1'b1, 6'h11, 8'hff);
        rd(6'h11, 8'h0f, "manual channel");
        check("conv valid", 32'h0, {31'h0, cv});
        bus(1'b1, 6'h10, 8'hff);
        rd(6'h10, 8'h13, "sequencing control");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 6'h10, m[7:0]);
            rd(6'h10, m[7:0], "scan mode");
        end
        bus(1'b1, 6'h10, 8'h00);
        bus(1'b1, 6'h11, 8'h06);
        check("conv select", 32'he, {28'h0, cv, ch});
        bus(1'b0, 6'h13, 8'h00);
        check("status", 32'h806, q);
        ext_en <= 8'hf0;
        ext_lv <= 8'ha0;
        bus(1'b1, 6'h05, 8'hff);
        bus(1'b1, 6'h07, 8'h0f);
        bus(1'b1, 6'h09, 8'h05);
        bus(1'b1, 6'h0b, 8'h03);
        check("pin enable", 32'hf2, {24'h0, oe_n});
        check("pin level", 32'ha3, {24'h0, pad_in});
        rd(6'h09, 8'h05, "drive type");
        bus(1'b1, 6'h0d, 8'hff);
        rd(6'h0d, 8'ha0, "input level");
        bus(1'b1, 6'h05, 8'h00);
        check("pin enable", 32'hff, {24'h0, oe_n});
        rd(6'h0d, 8'h00, "input level");
        bus(1'b0, 6'h3f, 8'h00);
        check("error answer", 32'h1, {31'h0, e});
        bus(1'b1, 6'h12, 8'ha4);
        bus(1'b1, 6'h10, 8'h11);
        for (int k = 0; k < 200 && seen.size() < 4; k++) begin
            @(posedge mclk);
            if (cv === 1'b1 && (seen.size() == 0 || seen[$] !== ch))
                seen.push_back(ch);
        end
        for (int i = 0; i < 3; i++)
            check("scan order", {29'h0, nx[seen[i]]}, {29'h0, seen[i+1]});
        bus(1'b1, 6'h10, 8'h01);
        check("scan stopped", 32'h0, {31'h0, cv});
        report_and_stop();
    end
endmodule
